// ---- design/pfs_pin_mux.sv ----
// Pin multiplexer for one eight-pin port.
module pfs_pin_mux
    import pfs_pkg::*;
#(
    parameter logic [7:0] ALT_MASK = 8'hFF,
    parameter logic [7:0] OUT_MASK = 8'hFF
)(
    input  wire logic [15:0] selWord,
    input  wire logic [7:0]  portData,
    input  wire logic [7:0]  altOut,
    input  wire logic [7:0]  altOe,
    input  wire logic [7:0]  padIn,
    output logic      [7:0]  padOut,
    output logic      [7:0]  padOe,
    output logic      [7:0]  pullUpEn,
    output logic      [7:0]  portIn,
    output logic      [7:0]  altIn
);

    // ------------------------------------------------------------
    // Per-pin decode
    // ------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < 8; n++)
        begin : g_pin
            logic [1:0] code;
            assign code = selWord[2*n+1 -: 2];
            always_comb
            begin
                padOut[n]   = 1'b0;
                padOe[n]    = 1'b0;
                pullUpEn[n] = 1'b0;
                case (code)
                    CODE_ALT:
                    begin
                        if (ALT_MASK[n])
                        begin
                            padOut[n] = altOut[n];
                            padOe[n]  = altOe[n];
                        end
                    end
                    CODE_OUT:
                    begin
                        // Drives from the port data bit. [RULE15]
                        if (OUT_MASK[n])
                        begin
                            padOut[n] = portData[n];
                            padOe[n]  = 1'b1;
                        end
                    end
                    CODE_PU:   pullUpEn[n] = 1'b1; // [RULE15]
                    CODE_NOPU: pullUpEn[n] = 1'b0;
                    default:   pullUpEn[n] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign portIn = padIn;
    assign altIn  = padIn;

endmodule : pfs_pin_mux

// ---- design/pfs_pkg.sv ----
// Constants shared by the port function select block.
package pfs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_PORT_H  = 12'h000;
    localparam logic [11:0] OFS_PORT_J  = 12'h004;
    localparam logic [11:0] OFS_PORT_K  = 12'h008;
    localparam logic [11:0] OFS_PORT_L  = 12'h00C;
    localparam logic [11:0] OFS_STATUS  = 12'h010;

    localparam int          NUM_PORTS   = 4;
    localparam int          PINS        = 8;
    localparam int          SEL_W       = 16;
    localparam logic [2:0]  IDX_H       = 3'h0;
    localparam logic [2:0]  IDX_J       = 3'h1;
    localparam logic [2:0]  IDX_K       = 3'h2;
    localparam logic [2:0]  IDX_L       = 3'h3;
    localparam logic [2:0]  IDX_STATUS  = 3'h4;
    localparam logic [2:0]  IDX_NONE    = 3'h7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PH_RST_HI   = 16'hAAAA;
    localparam logic [15:0] PH_RST_LO   = 16'h8AAA;
    localparam logic [15:0] PJ_RST      = 16'h0000;
    localparam logic [15:0] PK_RST      = 16'h0000;
    localparam logic [15:0] PL_RST      = 16'h0000;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [1:0]  CODE_ALT    = 2'h0;
    localparam logic [1:0]  CODE_OUT    = 2'h1;
    localparam logic [1:0]  CODE_PU     = 2'h2;
    localparam logic [1:0]  CODE_NOPU   = 2'h3;
    localparam int          STAT_EMU    = 0;

    // ------------------------------------------------------------
    // Per-port legal codes: bit n set means pin n offers the code
    // ------------------------------------------------------------
    localparam logic [7:0]  ALT_MASK_H  = 8'hFF;
    localparam logic [7:0]  ALT_MASK_J  = 8'hCD;
    localparam logic [7:0]  ALT_MASK_K  = 8'hFF;
    localparam logic [7:0]  ALT_MASK_L  = 8'hFF;
    localparam logic [7:0]  OUT_MASK_H  = 8'h80;
    localparam logic [7:0]  OUT_MASK_J  = 8'hFF;
    localparam logic [7:0]  OUT_MASK_K  = 8'hFF;
    localparam logic [7:0]  OUT_MASK_L  = 8'h00;

endpackage : pfs_pkg

// ---- design/pfs_port_function_select.sv ----
// Pin function select registers for ports H, J, K and L with APB access.
//
// Operation
// RULE1: Four 16-bit read/write registers; pin n uses bits 2n+1 and 2n.
// RULE2: Power-on reset loads port H with AAAA if mode pin high, else 8AAA.
// RULE3: Manual reset, standby and sleep leave all four registers unchanged.
// RULE4: Port H pin 7: alternate, output, input pull-up, input no pull-up.
// RULE5: Port H pin 6: no output; resets to 00 or 10 by mode pin.
// RULE6: Port H pins 0 to 5: alternate, reserved, pull-up input, plain input.
// RULE7: Power-on reset clears the port J register.
// RULE8: Port J: code 00 alternate on pins 0,2,3,6,7, reserved on 1,4,5.
// RULE9: Power-on reset clears the port K register.
// RULE10: Port K: all pins alternate, output, pull-up input, plain input.
// RULE11: Power-on reset clears the port L register.
// RULE12: Port L: output code reserved on all pins; others as usual.
// RULE13: Software keeps port L at reset value when converter pins are used.
// RULE14: Mode pin is sampled during reset, then serves as port G pin 6.
// RULE15: Output mode drives the data bit; input modes set pull-up by code.
//
// The address map and the APB register port were decided locally.
module pfs_port_function_select
    import pfs_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  manualRst,
    input  wire logic                  standbyReq,
    input  wire logic                  sleepReq,
    input  wire logic                  emulationModePin,
    output logic                       gportPin6In,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [3:0][7:0]       portData,
    input  wire logic [3:0][7:0]       altOut,
    input  wire logic [3:0][7:0]       altOe,
    input  wire logic [3:0][7:0]       padIn,
    output logic      [3:0][7:0]       padOut,
    output logic      [3:0][7:0]       padOe,
    output logic      [3:0][7:0]       pullUpEn,
    output logic      [3:0][7:0]       portIn,
    output logic      [3:0][7:0]       altIn
);
    import pfs_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [2:0] decodeIdx(input logic [11:0] addr);
        case (addr)
            OFS_PORT_H: decodeIdx = IDX_H;
            OFS_PORT_J: decodeIdx = IDX_J;
            OFS_PORT_K: decodeIdx = IDX_K;
            OFS_PORT_L: decodeIdx = IDX_L;
            OFS_STATUS: decodeIdx = IDX_STATUS;
            default:    decodeIdx = IDX_NONE;
        endcase
    endfunction : decodeIdx

    logic [3:0][15:0] selReg_ff;
    logic             initPending_ff;
    logic             emuSample_ff;
    logic [31:0]      prdata_ff;
    logic [2:0]       accIdx;
    logic             setupPhase;
    logic             accessDone;
    logic             wrDone;
    logic [15:0]      nxt_sel;

    assign accIdx     = decodeIdx(paddr);
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone     = accessDone && pwrite && (accIdx < IDX_STATUS);

    // ------------------------------------------------------------
    // Mode pin capture and port G pin 6 hand-over
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            emuSample_ff <= emulationModePin; // [RULE14]
        end
    end

    assign gportPin6In = rst ? 1'b0 : emulationModePin; // [RULE14]

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            initPending_ff <= 1'b1;
        end
        else
        begin
            initPending_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Function select registers
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_sel = selReg_ff[accIdx[1:0]];
        if (pstrb[0])
        begin
            nxt_sel[7:0] = pwdata[7:0];
        end
        if (pstrb[1])
        begin
            nxt_sel[15:8] = pwdata[15:8];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            selReg_ff[IDX_H[1:0]] <= PH_RST_HI;
            selReg_ff[IDX_J[1:0]] <= PJ_RST; // [RULE7]
            selReg_ff[IDX_K[1:0]] <= PK_RST; // [RULE9]
            selReg_ff[IDX_L[1:0]] <= PL_RST; // [RULE11]
        end
        else if (initPending_ff)
        begin
            // Port H value follows the level caught during reset.
            selReg_ff[IDX_H[1:0]] <= emuSample_ff ? PH_RST_HI
                                                  : PH_RST_LO; // [RULE2]
        end
        else if (wrDone)
        begin
            // Manual reset, standby and sleep have no path here. [RULE3]
            selReg_ff[accIdx[1:0]] <= nxt_sel; // [RULE1]
        end
    end

    // ------------------------------------------------------------
    // APB read data and answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prdata_ff <= 32'h0000_0000;
        end
        else if (setupPhase)
        begin
            case (accIdx)
                IDX_H, IDX_J, IDX_K, IDX_L:
                    prdata_ff <= {16'h0000, selReg_ff[accIdx[1:0]]};
                IDX_STATUS:
                    prdata_ff <= {31'h0000_0000, emuSample_ff};
                default:
                    prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = !initPending_ff;
    assign pslverr = psel && penable && (accIdx == IDX_NONE ||
                     (pwrite && accIdx == IDX_STATUS));

    // ------------------------------------------------------------
    // Pin multiplexers
    // ------------------------------------------------------------
    localparam logic [3:0][7:0] ALT_MASKS = {ALT_MASK_L, ALT_MASK_K,
                                             ALT_MASK_J, ALT_MASK_H};
    localparam logic [3:0][7:0] OUT_MASKS = {OUT_MASK_L, OUT_MASK_K,
                                             OUT_MASK_J, OUT_MASK_H};

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            // Per-port code legality. [RULE4] [RULE5] [RULE6] [RULE8]
            // Alternate and output codes per mask. [RULE10] [RULE12]
            pfs_pin_mux #(
                .ALT_MASK (ALT_MASKS[p]),
                .OUT_MASK (OUT_MASKS[p])
            ) u_mux (
                .selWord  (selReg_ff[p]),
                .portData (portData[p]),
                .altOut   (altOut[p]),
                .altOe    (altOe[p]),
                .padIn    (padIn[p]),
                .padOut   (padOut[p]),
                .padOe    (padOe[p]),
                .pullUpEn (pullUpEn[p]),
                .portIn   (portIn[p]),
                .altIn    (altIn[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_wr_done;
        wrDone && pstrb[1:0] == 2'h3;
    endsequence

    sequence s_rd_setup;
        setupPhase && !pwrite && accIdx < IDX_STATUS;
    endsequence

    property p_ph_init_hi;
        @(posedge clk_sys) disable iff (rst)
        initPending_ff && emuSample_ff |=> selReg_ff[0] == PH_RST_HI;
    endproperty
    a_ph_init_hi: assert property (p_ph_init_hi) // [RULE2]
        else $error("Port H reset value wrong with mode pin high.");

    property p_ph_init_lo;
        @(posedge clk_sys) disable iff (rst)
        initPending_ff && !emuSample_ff
            |=> selReg_ff[0][13:12] == CODE_ALT
                && selReg_ff[0][15:14] == CODE_PU; // [RULE5]
    endproperty
    a_ph_init_lo: assert property (p_ph_init_lo) // [RULE2]
        else $error("Port H reset value wrong with mode pin low.");

    property p_jkl_init;
        @(posedge clk_sys) disable iff (rst)
        initPending_ff |-> selReg_ff[1] == PJ_RST && selReg_ff[2] == PK_RST
                           && selReg_ff[3] == PL_RST;
    endproperty
    a_jkl_init: assert property (p_jkl_init) // [RULE7] [RULE9] [RULE11]
        else $error("Port J, K or L register not cleared at reset.");

    property p_write;
        logic [2:0]  idx;
        logic [15:0] val;
        @(posedge clk_sys) disable iff (rst)
        (s_wr_done, idx = accIdx, val = pwdata[15:0])
            |=> selReg_ff[idx[1:0]] == val;
    endproperty
    a_write: assert property (p_write) // [RULE1]
        else $error("Register write did not take effect.");

    property p_read;
        logic [15:0] val;
        @(posedge clk_sys) disable iff (rst)
        (s_rd_setup, val = selReg_ff[accIdx[1:0]])
            ##1 (psel && penable) |-> prdata == {16'h0000, val};
    endproperty
    a_read: assert property (p_read) // [RULE1]
        else $error("Read data does not match register.");

    property p_low_power_hold;
        @(posedge clk_sys) disable iff (rst)
        (manualRst || standbyReq || sleepReq) && !wrDone && !initPending_ff
            |=> $stable(selReg_ff);
    endproperty
    a_low_power_hold: assert property (p_low_power_hold) // [RULE3]
        else $error("Register changed by manual reset, standby or sleep.");

    property p_gport_pin6;
        @(posedge clk_sys) disable iff (rst)
        gportPin6In == emulationModePin;
    endproperty
    a_gport_pin6: assert property (p_gport_pin6) // [RULE14]
        else $error("Port G pin 6 does not follow the pad after reset.");

    property p_k_output;
        @(posedge clk_sys) disable iff (rst)
        selReg_ff[2][1:0] == CODE_OUT
            |-> padOe[2][0] && padOut[2][0] == portData[2][0];
    endproperty
    a_k_output: assert property (p_k_output) // [RULE10] [RULE15]
        else $error("Port K pin 0 not driving in output mode.");

    property p_l_no_output;
        @(posedge clk_sys) disable iff (rst)
        selReg_ff[3][15:14] == CODE_OUT |-> !padOe[3][7] && !pullUpEn[3][7];
    endproperty
    a_l_no_output: assert property (p_l_no_output) // [RULE12]
        else $error("Port L pin 7 drives under a reserved code.");

    property p_h_pullup;
        @(posedge clk_sys) disable iff (rst)
        selReg_ff[0][1:0] == CODE_PU |-> pullUpEn[0][0] && !padOe[0][0];
    endproperty
    a_h_pullup: assert property (p_h_pullup) // [RULE6] [RULE15]
        else $error("Port H pin 0 pull-up input decoded wrongly.");

    property p_h6_no_output;
        @(posedge clk_sys) disable iff (rst)
        selReg_ff[0][13:12] == CODE_OUT |-> !padOe[0][6];
    endproperty
    a_h6_no_output: assert property (p_h6_no_output) // [RULE5]
        else $error("Port H pin 6 drives under a reserved code.");

    property p_h7_output;
        @(posedge clk_sys) disable iff (rst)
        selReg_ff[0][15:14] == CODE_OUT
            |-> padOe[0][7] && padOut[0][7] == portData[0][7];
    endproperty
    a_h7_output: assert property (p_h7_output) // [RULE4]
        else $error("Port H pin 7 not driving in output mode.");

    property p_j1_reserved;
        @(posedge clk_sys) disable iff (rst)
        selReg_ff[1][3:2] == CODE_ALT |-> !padOe[1][1];
    endproperty
    a_j1_reserved: assert property (p_j1_reserved) // [RULE8]
        else $error("Port J pin 1 drives under a reserved code.");

    property p_unmapped;
        @(posedge clk_sys) disable iff (rst)
        psel && penable && accIdx == IDX_NONE |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped access did not report an error.");

endmodule : pfs_port_function_select

// ---- sim/pfs_pad_model.sv ----
// Board-side model of the port pads and their pull-ups.
module pfs_pad_model
(
    input  wire logic [3:0][7:0] padOut,
    input  wire logic [3:0][7:0] padOe,
    input  wire logic [3:0][7:0] pullUpEn,
    input  wire logic [3:0][7:0] extLevel,
    output logic      [3:0][7:0] padIn
);
    timeunit 1ns;
    timeprecision 1ns;

    // Driven pins show the block's value, pulled pins read high, and
    // floating pins show whatever the board puts there.
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                if (padOe[p][b])
                    padIn[p][b] = padOut[p][b];
                else if (pullUpEn[p][b])
                    padIn[p][b] = 1'b1;
                else
                    padIn[p][b] = extLevel[p][b];
            end
        end
    end
endmodule : pfs_pad_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the port function select block.
module tb_top;
    import pfs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys, rst, manualRst, standbyReq, sleepReq;
    logic emulationModePin, gportPin6In;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [3:0][7:0] portData, altOut, altOe, padIn, extLevel;
    logic [3:0][7:0] padOut, padOe, pullUpEn, portIn, altIn;
    logic [15:0] lfsr = 16'h0045;
    logic [15:0] refReg [4];
    logic [11:0] offs [4] = '{OFS_PORT_H, OFS_PORT_J, OFS_PORT_K,
                              OFS_PORT_L};
    logic [7:0] altM [4] = '{ALT_MASK_H, ALT_MASK_J, ALT_MASK_K, ALT_MASK_L};
    logic [7:0] outM [4] = '{OUT_MASK_H, OUT_MASK_J, OUT_MASK_K, OUT_MASK_L};
    int failures = 0;
    int checks_done = 0;
    logic [31:0] rdTmp;
    logic        errTmp;

    pfs_port_function_select DUT (.clk_sys(clk_sys), .rst(rst),
        .manualRst(manualRst), .standbyReq(standbyReq), .sleepReq(sleepReq),
        .emulationModePin(emulationModePin), .gportPin6In(gportPin6In),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portData(portData), .altOut(altOut),
        .altOe(altOe), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUpEn), .portIn(portIn), .altIn(altIn));

    pfs_pad_model PADS (.padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUpEn), .extLevel(extLevel), .padIn(padIn));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            failures++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wreg(input int p, input logic [15:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, offs[p], {16'h0, v}, r, e);
        chk({31'h0, e}, 32'h0);
        refReg[p] = v;
    endtask : wreg

    task automatic rreg(input int p);
        logic [31:0] r;
        logic e;
        apb(1'b0, offs[p], 32'h0, r, e);
        chk(r, {16'h0, refReg[p]});
        chk({31'h0, e}, 32'h0);
    endtask : rreg

    task automatic bad(input logic wr, input logic [11:0] a);
        logic [31:0] r;
        logic e;
        apb(wr, a, 32'hFFFF, r, e);
        chk({31'h0, e}, 32'h1);
        if (!wr)
            chk(r, 32'h0);
    endtask : bad

    task automatic stat(input logic exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        chk(r, {31'h0, exp});
        chk({31'h0, e}, 32'h0);
    endtask : stat

    task automatic doReset(input logic strap);
        emulationModePin <= strap;
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({31'h0, gportPin6In}, 32'h0);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        refReg = '{strap ? PH_RST_HI : PH_RST_LO, PJ_RST, PK_RST, PL_RST};
    endtask : doReset

    task automatic pins(input int p, input logic [1:0] c);
        logic [7:0] oe, pu, ov;
        wreg(p, {8{c}});
        portData[p] <= rnd();
        altOut[p]   <= rnd();
        altOe[p]    <= rnd();
        extLevel[p] <= rnd();
        @(posedge clk_sys);
        @(negedge clk_sys);
        for (int b = 0; b < 8; b++)
        begin
            oe[b] = 1'b0;
            ov[b] = 1'b0;
            pu[b] = (c == CODE_PU);
            if (c == CODE_ALT && altM[p][b])
            begin
                oe[b] = altOe[p][b];
                ov[b] = altOut[p][b];
            end
            if (c == CODE_OUT && outM[p][b])
            begin
                oe[b] = 1'b1;
                ov[b] = portData[p][b];
            end
        end
        chk({24'h0, padOe[p]}, {24'h0, oe});
        chk({24'h0, padOut[p] & oe}, {24'h0, ov & oe});
        chk({24'h0, pullUpEn[p]}, {24'h0, pu});
        chk({16'h0, altIn[p], portIn[p]},
            {16'h0, padIn[p], padIn[p]});
    endtask : pins

    initial
    begin
        {rst, manualRst, standbyReq, sleepReq, psel, penable, pwrite} = '0;
        emulationModePin = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        {portData, altOut, altOe, extLevel} = '0;
        doReset(1'b0);
        for (int p = 0; p < 4; p++)
            rreg(p);
        stat(1'b0);
        $display("test reset values done");
        for (int p = 0; p < 4; p++)
            wreg(p, {rnd(), rnd()});
        for (int p = 0; p < 4; p++)
            rreg(p);
        $display("test read write done");
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 4; c++)
                pins(p, c[1:0]);
        wreg(3, PL_RST);
        $display("test pin functions done");
        manualRst  <= 1'b1;
        standbyReq <= 1'b1;
        sleepReq   <= 1'b1;
        repeat (3) @(posedge clk_sys);
        {manualRst, standbyReq, sleepReq} <= '0;
        @(posedge clk_sys);
        for (int p = 0; p < 4; p++)
            rreg(p);
        $display("test low power hold done");
        bad(1'b1, 12'h014);
        bad(1'b0, 12'h014);
        bad(1'b1, OFS_STATUS);
        pstrb <= 4'h1;
        apb(1'b1, OFS_PORT_H, 32'h0000_5555, rdTmp, errTmp);
        pstrb <= 4'hF;
        chk({31'h0, errTmp}, 32'h0);
        refReg[0][7:0] = 8'h55;
        for (int p = 0; p < 4; p++)
            rreg(p);
        $display("test refused access done");
        doReset(1'b1);
        rreg(0);
        chk({31'h0, gportPin6In}, 32'h1);
        emulationModePin <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, gportPin6In}, 32'h0);
        stat(1'b1);
        rreg(0);
        $display("test strap high done");
        end_of_test();
    end
endmodule : tb_top
